//--- bench/ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model (
  input wire logic mclk,
  input wire logic srst,
  input wire strobe_pkg::strobes_t strobes,
  // Falling edges seen, one counter per strobe bit
  output logic [3:0][15:0] cnt
);
  strobe_pkg::strobes_t last_r;
  always_ff @(posedge mclk) begin
    last_r <= strobes;
    // Each strobe bit's falling edge bumps its own counter
    for (int i = 0; i < 4; i++) begin
      if (srst) cnt[i] <= 16'h0000;
      else if (last_r[i] && !strobes[i]) cnt[i] <= cnt[i] + 16'h0001;
    end
  end
endmodule : ext_mem_model

//--- bench/ext_mem_strobe_chk.sv
`timescale 1ns/10ps
module ext_mem_strobe_chk #(parameter int PORT_W = 8) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [PORT_W-1:0] port4Latch,
  input wire strobe_pkg::strobes_t strobes,
  input wire logic [PORT_W-1:0] port4PullUp,
  input wire logic deviceReset,
  input wire logic linkReset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic ale = strobes.addrLatch;
  wire logic fn = strobes.fetchStrobeN;
  property p_hold; deviceReset [*3] |-> ale && fn; endproperty
  a_hold: assert property (p_hold) else $error("strobe low in reset");
  property p_calm; deviceReset [*3] |-> $stable(strobes); endproperty
  a_calm: assert property (p_calm) else $error("strobe moved in reset");
  property p_ale; $rose(ale) && !deviceReset |=> ale ##1 (!ale || deviceReset); endproperty
  a_ale: assert property (p_ale) else $error("latch width");
  property p_fetch; $fell(fn) |=> (!fn || deviceReset) [*3] ##1 fn; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch width");
  property p_skip; !(strobes.dataRdN && strobes.dataWrN) |-> fn && !ale; endproperty
  a_skip: assert property (p_skip) else $error("fetch during data");
  property p_one; strobes.dataRdN || strobes.dataWrN; endproperty
  a_one: assert property (p_one) else $error("both data strobes");
  property p_pull; !$past(srst) |-> port4PullUp == $past(port4Latch); endproperty
  a_pull: assert property (p_pull) else $error("pull-up");
  property p_link; linkReset == deviceReset; endproperty
  a_link: assert property (p_link) else $error("link reset");
  cover property ($fell(strobes.dataWrN));
  cover property ($fell(strobes.dataRdN));
  cover property ($rose(deviceReset));
endmodule : ext_mem_strobe_chk
bind ext_mem_strobe_reset_ctl ext_mem_strobe_chk #(.PORT_W(PORT_W)) u_chk (.mclk(mclk), .srst(srst),
  .port4Latch(port4Latch), .strobes(strobes), .port4PullUp(port4PullUp), .deviceReset(deviceReset), .linkReset(linkReset));

//--- bench/tb_ext_mem_strobe_reset_ctl.sv
`timescale 1ns/10ps
module tb_ext_mem_strobe_reset_ctl;
  logic mclk = 1'b0, srst = 1'b1, resetPinN = 1'b1, dataAccessReq = 1'b0, dataAccessWrite = 1'b0;
  logic [7:0] port4PullUp, port4Read;
  logic deviceReset, linkReset, linkTxEnable;
  logic [3:0][15:0] cnt, base;
  logic [63:0] d;
  strobe_pkg::strobes_t strobes;
  int failures = 0, comparisons = 0;
  ext_mem_strobe_reset_ctl DUT (.mclk(mclk), .srst(srst), .resetPinN(resetPinN), .extProgram(1'b1),
    .dataAccessReq(dataAccessReq), .dataAccessWrite(dataAccessWrite), .port4Latch(8'h0f), .port4PinIn(8'h35),
    .strobes(strobes), .port4PullUp(port4PullUp), .port4Read(port4Read), .deviceReset(deviceReset),
    .linkReset(linkReset), .linkTxEnable(linkTxEnable));
  ext_mem_model MEM (.mclk(mclk), .srst(srst), .strobes(strobes), .cnt(cnt));
  initial forever #25 mclk = ~mclk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wait_release;
    for (int i = 0; i < 400 && deviceReset !== 1'b0; i++) @(negedge mclk);
    if (deviceReset !== 1'b0) failures++;
    if (deviceReset !== 1'b0) report_and_stop;
  endtask : wait_release
  // Edge deltas since base: latch, fetch, write, read
  task automatic span(input int n);
    repeat (n) @(negedge mclk);
    d = {cnt[3] - base[3], cnt[2] - base[2], cnt[1] - base[1], cnt[0] - base[0]};
  endtask : span
  // Request held two edges: the second sample must be refused
  task automatic t_access(input logic wr);
    base = cnt;
    dataAccessWrite = wr;
    dataAccessReq = 1'b1;
    repeat (2) @(negedge mclk);
    dataAccessReq = 1'b0;
    span(238);
    check(d, {32'h0027_0026, 15'h0000, wr, 15'h0000, !wr});
  endtask : t_access
  task automatic t_pin;
    resetPinN = 1'b0;
    span(24);
    resetPinN = 1'b1;
    span(4);
    check(deviceReset, 1'b0);
    resetPinN = 1'b0;
    span(150);
    check({deviceReset, linkReset, linkTxEnable, strobes.addrLatch, strobes.fetchStrobeN}, 5'h1b);
    base = cnt;
    span(48);
    check(d, 64'h0000);
    resetPinN = 1'b1;
    wait_release;
  endtask : t_pin
  initial begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    wait_release;
    base = cnt;
    span(240);
    check(d, 64'h0028_0028_0000_0000);
    check({port4PullUp, port4Read}, 16'h0f05);
    t_access(1'b1);
    t_access(1'b0);
    t_pin;
    report_and_stop;
  end
endmodule : tb_ext_mem_strobe_reset_ctl

//--- hw/ext_mem_strobe_reset_ctl.sv
`timescale 1ns/10ps
module ext_mem_strobe_reset_ctl #(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Pins
  input wire logic resetPinN,
  input wire logic extProgram,
  // Core requests
  input wire logic dataAccessReq,
  input wire logic dataAccessWrite,
  input wire logic [PORT_W-1:0] port4Latch,
  input wire logic [PORT_W-1:0] port4PinIn,
  // Outputs
  output strobe_pkg::strobes_t strobes,
  output logic [PORT_W-1:0] port4PullUp,
  output logic [PORT_W-1:0] port4Read,
  output logic deviceReset,
  output logic linkReset,
  output logic linkTxEnable
);
  initial begin
    if (PORT_W < 1) $error("PORT_W must be positive");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic rstMeta_r, rstSync_r;
  logic [PORT_W-1:0] p4Meta_r, p4Sync_r;
  always_ff @(posedge mclk) begin
    rstMeta_r <= resetPinN;
    rstSync_r <= rstMeta_r;
    p4Meta_r <= port4PinIn;
    p4Sync_r <= p4Meta_r;
  end

  // ****************************************
  // Timing: divide-by-two then six states
  // ****************************************
  // mclk stands for the oscillator; halving it first makes duty cycle irrelevant.
  // Three states of two periods make one latch period, two of those a machine cycle.
  logic half_r, half_nxt;
  logic [3:0] phase_r, phase_nxt;
  logic stateHalf_r, stateHalf_nxt;
  wire logic phaseWrap = (phase_r == strobe_pkg::PHASE_LAST);
  wire logic mcEnd = half_r & phaseWrap & stateHalf_r;
  assign half_nxt = ~half_r; // R12
  assign phase_nxt = ~half_r ? phase_r : (phaseWrap ? 4'h0 : phase_r + 4'h1); // R13
  assign stateHalf_nxt = (half_r & phaseWrap) ? ~stateHalf_r : stateHalf_r; // R13

  // ****************************************
  // Reset qualification
  // ****************************************
  logic [1:0] lowMc_r, lowMc_nxt;
  logic [2:0] linkMc_r, linkMc_nxt;
  logic inReset_r, inReset_nxt;
  wire logic pinLow = ~rstSync_r;
  // Low must persist over three whole machine cycles; a glitch restarts the count
  assign lowMc_nxt = !pinLow ? 2'h0 : ((mcEnd && lowMc_r != strobe_pkg::RST_MC) ? lowMc_r + 2'h1 : lowMc_r);
  // The first boundary may come early, so one more boundary is needed for three full cycles
  assign inReset_nxt = pinLow ? (inReset_r | ((lowMc_r == strobe_pkg::RST_MC) & mcEnd)) : 1'b0; // R1
  assign linkMc_nxt = !pinLow ? 3'h0 : ((mcEnd && linkMc_r != strobe_pkg::LINK_STOP_MC) ? linkMc_r + 3'h1 : linkMc_r);

  // ****************************************
  // Data memory access sequencing
  // ****************************************
  strobe_pkg::acc_state_t acc_r, acc_nxt;
  logic accWrite_r, accWrite_nxt;
  wire logic mcStart = half_r & phaseWrap & stateHalf_r;
  always_comb begin
    acc_nxt = acc_r;
    case (acc_r)
      strobe_pkg::IDLE: if (dataAccessReq) acc_nxt = strobe_pkg::ACC_PENDING;
      strobe_pkg::ACC_PENDING: if (mcStart) acc_nxt = strobe_pkg::ACC_ACTIVE;
      strobe_pkg::ACC_ACTIVE: if (mcEnd) acc_nxt = strobe_pkg::IDLE;
      default: acc_nxt = strobe_pkg::IDLE;
    endcase
  end
  assign accWrite_nxt = (acc_r == strobe_pkg::IDLE && dataAccessReq) ? dataAccessWrite : accWrite_r;
  wire logic accActive = (acc_r == strobe_pkg::ACC_ACTIVE);

  // ****************************************
  // Strobe decode
  // ****************************************
  // The access spans one machine cycle: its first ALE pulse is kept for address,
  // second ALE pulse and both fetch strobes in that cycle dropped
  wire logic aleWindow = (phase_r[2:0] >= strobe_pkg::ALE_HI_START) && (phase_r[2:0] <= strobe_pkg::ALE_HI_END);
  wire logic aleSkip = accActive & stateHalf_r; // R4
  wire logic aleNxt = inReset_r | (aleWindow & ~aleSkip); // R3 R5 R6
  wire logic fetchWindow = (phase_r[2:0] >= strobe_pkg::FETCH_LO_START) && (phase_r[2:0] <= strobe_pkg::FETCH_LO_END);
  wire logic fetchNNxt = inReset_r | ~extProgram | ~fetchWindow | accActive; // R7 R8 R9
  wire logic dataStrobe = accActive & stateHalf_r & fetchWindow;
  wire logic wrNNxt = ~(dataStrobe & accWrite_r & ~inReset_r); // R10
  wire logic rdNNxt = ~(dataStrobe & ~accWrite_r & ~inReset_r); // R10

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      half_r <= 1'b0;
      phase_r <= 4'h0;
      stateHalf_r <= 1'b0;
      lowMc_r <= 2'h0;
      linkMc_r <= 3'h0;
      inReset_r <= 1'b1;
      acc_r <= strobe_pkg::IDLE;
      accWrite_r <= 1'b0;
      strobes <= '{addrLatch: 1'b1, fetchStrobeN: 1'b1, dataWrN: 1'b1, dataRdN: 1'b1};
      port4PullUp <= '0;
      port4Read <= '0;
      deviceReset <= 1'b1;
      linkReset <= 1'b1;
      linkTxEnable <= 1'b0;
    end else begin
      half_r <= half_nxt;
      phase_r <= phase_nxt;
      stateHalf_r <= stateHalf_nxt;
      lowMc_r <= lowMc_nxt;
      linkMc_r <= linkMc_nxt;
      inReset_r <= inReset_nxt;
      acc_r <= inReset_r ? strobe_pkg::IDLE : acc_nxt;
      accWrite_r <= accWrite_nxt;
      strobes <= '{addrLatch: aleNxt, fetchStrobeN: fetchNNxt, dataWrN: wrNNxt, dataRdN: rdNNxt};
      port4PullUp <= port4Latch; // R11
      port4Read <= p4Sync_r & port4Latch; // R11
      deviceReset <= inReset_nxt; // R1
      linkReset <= inReset_nxt; // R2
      linkTxEnable <= ~(pinLow && linkMc_r == strobe_pkg::LINK_STOP_MC); // R2
    end
  end
endmodule : ext_mem_strobe_reset_ctl

//--- hw/strobe_pkg.sv
// Function
// R1 - The reset input must stay low for three machine cycles with the oscillator running before the device resets.
// R2 - Once reset is first applied the serial link controller sees it after three machine cycles and may keep sending for up to four.
// R3 - In normal operation the address latch strobe runs at one sixth of the oscillator frequency.
// R4 - Each external data memory access drops exactly one address latch strobe pulse.
// R5 - While in reset the address latch strobe stays high with no pulses.
// R6 - External logic latches the low address byte with the address latch strobe.
// R7 - When fetching from external program memory the active-low fetch strobe fires twice per machine cycle.
// R8 - Each external data memory access skips two fetch strobe activations.
// R9 - While in reset the fetch strobe stays high.
// R10 - Two third-port alternate pins give the data memory write and read strobes.
// R11 - A fourth-port pin written with one is pulled high and serves as input.
// R12 - The oscillator passes a divide-by-two stage before internal clocking.
// R13 - A machine cycle is twelve oscillator periods, holding two address latch strobe pulses.
package strobe_pkg;
  localparam int OSC_PER_MC = 12;
  localparam int STATE_TICKS = 6;
  localparam logic [3:0] PHASE_LAST = 4'h2;
  localparam logic [1:0] RST_MC = 2'h3;
  localparam logic [2:0] LINK_STOP_MC = 3'h4;
  localparam logic [2:0] ALE_HI_START = 3'h0;
  localparam logic [2:0] ALE_HI_END = 3'h0;
  localparam logic [2:0] FETCH_LO_START = 3'h1;
  localparam logic [2:0] FETCH_LO_END = 3'h2;

  typedef struct packed {
    logic addrLatch;
    logic fetchStrobeN;
    logic dataWrN;
    logic dataRdN;
  } strobes_t;

  typedef enum logic [1:0] {IDLE, ACC_PENDING, ACC_ACTIVE} acc_state_t;
endpackage : strobe_pkg
